// file: dapf_pkg.sv
// package of the attack packet filter: offsets, fields, reset values
// assumes one 100 MHz core clock shared by parser, filter and bus
package dapf_pkg;

  // ---------------------------------------------------------------
  // signatures
  // ---------------------------------------------------------------
  localparam int SIG_N        = 8;
  localparam int SIG_EQ_PORT  = 0;
  localparam int SIG_EQ_ADDR  = 1;
  localparam int SIG_NULL     = 2;
  localparam int SIG_SYN_FIN  = 3;
  localparam int SIG_LOW_PORT = 4;
  localparam int SIG_XMAS     = 5;
  localparam int SIG_BIG_PING = 6;
  localparam int SIG_TINY     = 7;

  // ---------------------------------------------------------------
  // tcp flag positions
  // ---------------------------------------------------------------
  localparam int FLG_FIN = 0;
  localparam int FLG_SYN = 1;
  localparam int FLG_PSH = 3;
  localparam int FLG_URG = 5;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_ALL      = 8'h04;
  localparam logic [7:0] ADDR_ENABLE   = 8'h08;
  localparam logic [7:0] ADDR_TARGET   = 8'h0C;
  localparam logic [7:0] ADDR_INT_STAT = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h20;
  localparam logic [7:0] ADDR_CNT_LAST = 8'h3C;

  // field positions
  localparam int CTRL_NOTIFY   = 0;
  localparam int ALL_ON        = 0;
  localparam int INT_EVENT     = 0;
  localparam int INT_DROP      = 1;
  localparam int STAT_SEEN     = 0;
  localparam int STAT_ACTIVE   = 1;
  localparam int STAT_EN_LSB   = 8;

  // reset values
  localparam logic [7:0]  ENABLE_RST = 8'h00;
  localparam logic [31:0] TARGET_RST = 32'h00000000;
  localparam logic [1:0]  INT_RST    = 2'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ---------------------------------------------------------------
  // length limits
  // ---------------------------------------------------------------
  localparam logic [16:0] IP_MAX_LEN    = 17'h0FFFF;
  localparam logic [15:0] TCP_MIN_HDR   = 16'h0014;
  localparam logic [15:0] LOW_PORT_END  = 16'h0400;
  localparam logic [12:0] FRAG_OFF_ONE  = 13'h0001;

  // ---------------------------------------------------------------
  // interval timing
  // ---------------------------------------------------------------
  localparam int          TMR_W         = 35;
  localparam longint      INTERVAL_S    = 300;
  localparam longint      CLK_HZ        = 100_000_000;
  localparam logic [TMR_W-1:0] INTERVAL_CYCLES =
    TMR_W'(INTERVAL_S * CLK_HZ);

  // ---------------------------------------------------------------
  // parsed header summary from the ingress parser
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        is_ip;
    logic        is_tcp;
    logic        is_udp;
    logic        is_ping;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [31:0] tcp_seq;
    logic [5:0]  tcp_flags;
    logic [15:0] total_len;
    logic [3:0]  ihl;
    logic        more_frag;
    logic [12:0] frag_off;
  } dapf_pkt_s;

endpackage

// file: dapf_drop_counter.sv
// one saturating drop counter, cleared on request
// assumes inc and clear come from logic on the same clock
`timescale 1ns/10ps
module dapf_drop_counter #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // control
  input  wire logic         clear,
  input  wire logic         inc,
  // value
  output logic [W-1:0]      count
);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (inc && (count != {W{1'b1}})) begin
      count <= count + 1'b1;
    end
  end

  property p_saturate;
    @(posedge clock) disable iff (!rst_n)
      (!clear && inc && count == {W{1'b1}}) |=> count == {W{1'b1}};
  endproperty
  a_saturate: assert property (p_saturate) // RULE12
    else $error("drop counter wrapped");

endmodule

// file: dapf_filter.sv
// attack packet filter: signature match, drop counts, interval event
// assumes parser gives one header summary per pkt_valid cycle
//
// Notes on behaviour
// RULE1: flag tcp or udp with equal ports
// RULE2: flag ip with both addresses equal target
// RULE3: flag tcp seq zero, no flags
// RULE4: flag tcp with syn and fin
// RULE5: flag tcp syn from port below 1024
// RULE6: flag tcp seq zero with urg psh fin
// RULE7: flag ping reassembling beyond 65535 bytes
// RULE8: flag fragments splitting off tcp header
// RULE9: separate enables, all clear after reset
// RULE10: one control sets or clears all
// RULE11: matching and drop done in hardware
// RULE12: readable enables and per-signature drop counters
// RULE13: one event per attacked five-minute interval
// RULE14: event forwarding gated, off after reset
// RULE15: sticky seen flag cleared at interval end
`timescale 1ns/10ps
module dapf_filter #(
  parameter logic [dapf_pkg::TMR_W-1:0] INTERVAL_CYCLES =
    dapf_pkg::INTERVAL_CYCLES
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // packet path
  input  wire logic                 pkt_valid,
  input  wire dapf_pkg::dapf_pkt_s  pkt,
  output logic                      verdict_valid,
  output logic                      drop,
  output logic [7:0]                drop_vec,
  // notification
  output logic                      attack_event,
  output logic                      irq,
  // axi4-lite write
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0]                 ctrl;
  logic [7:0]                  enable;
  logic [31:0]                 target_ip;
  logic [1:0]                  int_stat;
  logic [1:0]                  int_mask;
  logic                        attack_seen;
  logic [dapf_pkg::TMR_W-1:0]  tmr;
  logic [7:0]                  match;
  logic [31:0]                 cnt [8];
  logic                        wr_fire;
  logic                        rd_fire;
  logic                        all_write;
  logic                        cnt_clear;
  logic                        prev_on;
  logic                        expire;
  logic                        hit;
  logic                        raise_event;
  logic [16:0]                 reasm_len;
  logic [15:0]                 l4_len;
  logic                        is_l4;
  logic                        seq_zero;
  logic [31:0]                 next_rdata;
  logic [1:0]                  next_rresp;

  // ---------------------------------------------------------------
  // signature match
  // ---------------------------------------------------------------
  assign is_l4     = pkt.is_tcp || pkt.is_udp;
  assign seq_zero  = (pkt.tcp_seq == 32'h00000000);
  assign reasm_len = {1'b0, pkt.frag_off, 3'h0} + {1'b0, pkt.total_len};
  assign l4_len    = pkt.total_len - {10'h000, pkt.ihl, 2'h0};

  always_comb begin
    match = 8'h00;
    match[dapf_pkg::SIG_EQ_PORT] = is_l4 &&
      (pkt.src_port == pkt.dst_port); // RULE1
    match[dapf_pkg::SIG_EQ_ADDR] = pkt.is_ip &&
      (pkt.src_ip == target_ip) && (pkt.dst_ip == target_ip); // RULE2
    match[dapf_pkg::SIG_NULL] = pkt.is_tcp && seq_zero &&
      (pkt.tcp_flags == 6'h00); // RULE3
    match[dapf_pkg::SIG_SYN_FIN] = pkt.is_tcp &&
      pkt.tcp_flags[dapf_pkg::FLG_SYN] &&
      pkt.tcp_flags[dapf_pkg::FLG_FIN]; // RULE4
    match[dapf_pkg::SIG_LOW_PORT] = pkt.is_tcp &&
      pkt.tcp_flags[dapf_pkg::FLG_SYN] &&
      (pkt.src_port < dapf_pkg::LOW_PORT_END); // RULE5
    match[dapf_pkg::SIG_XMAS] = pkt.is_tcp && seq_zero &&
      pkt.tcp_flags[dapf_pkg::FLG_URG] &&
      pkt.tcp_flags[dapf_pkg::FLG_PSH] &&
      pkt.tcp_flags[dapf_pkg::FLG_FIN]; // RULE6
    match[dapf_pkg::SIG_BIG_PING] = pkt.is_ping &&
      (reasm_len > dapf_pkg::IP_MAX_LEN); // RULE7
    match[dapf_pkg::SIG_TINY] = pkt.is_tcp && (
      (pkt.frag_off == 13'h0000 && pkt.more_frag &&
       l4_len < dapf_pkg::TCP_MIN_HDR) ||
      (pkt.frag_off == dapf_pkg::FRAG_OFF_ONE)); // RULE8
    match = match & enable; // RULE9
  end

  assign hit = pkt_valid && (match != 8'h00);

  // ---------------------------------------------------------------
  // verdict to forwarding pipeline
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      verdict_valid <= 1'b0;
      drop          <= 1'b0;
      drop_vec      <= 8'h00;
    end else begin
      verdict_valid <= pkt_valid; // RULE11
      drop          <= hit; // RULE11
      drop_vec      <= pkt_valid ? match : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // drop counters
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < dapf_pkg::SIG_N; gi++) begin : g_cnt
      dapf_drop_counter #(.W(32)) u_cnt (
        .clock (clock),
        .rst_n (rst_n),
        .clear (cnt_clear),
        .inc   (pkt_valid && match[gi]), // RULE12
        .count (cnt[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // axi write channel
  // ---------------------------------------------------------------
  assign wr_fire   = s_axi_awvalid && s_axi_awready &&
                     s_axi_wvalid && s_axi_wready;
  assign all_write = wr_fire && (s_axi_awaddr == dapf_pkg::ADDR_ALL) &&
                     s_axi_wstrb[0];
  assign cnt_clear = all_write && !s_axi_wdata[dapf_pkg::ALL_ON];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid &&
                       s_axi_wvalid && !s_axi_bvalid;
      s_axi_wready  <= !s_axi_wready && s_axi_awvalid &&
                       s_axi_wvalid && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dapf_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr > dapf_pkg::ADDR_INT_MASK ||
                       s_axi_awaddr[1:0] != 2'h0) ?
                      dapf_pkg::RESP_DECERR : dapf_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= 32'h00000000;
      target_ip <= dapf_pkg::TARGET_RST;
      int_mask  <= dapf_pkg::INT_RST;
    end else if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        if (s_axi_wstrb[b]) begin
          if (s_axi_awaddr == dapf_pkg::ADDR_CTRL)
            ctrl[8*b +: 8] <= s_axi_wdata[8*b +: 8]; // RULE14
          if (s_axi_awaddr == dapf_pkg::ADDR_TARGET)
            target_ip[8*b +: 8] <= s_axi_wdata[8*b +: 8];
        end
      end
      if (s_axi_awaddr == dapf_pkg::ADDR_INT_MASK && s_axi_wstrb[0])
        int_mask <= s_axi_wdata[1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable <= dapf_pkg::ENABLE_RST; // RULE9
    end else if (all_write) begin
      enable <= s_axi_wdata[dapf_pkg::ALL_ON] ?
                8'hFF : dapf_pkg::ENABLE_RST; // RULE10
    end else if (wr_fire && s_axi_wstrb[0] &&
                 s_axi_awaddr == dapf_pkg::ADDR_ENABLE) begin
      enable <= s_axi_wdata[7:0]; // RULE9
    end
  end

  // ---------------------------------------------------------------
  // five-minute interval
  // ---------------------------------------------------------------
  assign prev_on     = (enable != 8'h00);
  assign expire      = prev_on && (tmr == INTERVAL_CYCLES - 1'b1);
  assign raise_event = expire && attack_seen && ctrl[dapf_pkg::CTRL_NOTIFY];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmr <= '0;
    end else if (!prev_on || expire) begin
      tmr <= '0; // RULE13
    end else begin
      tmr <= tmr + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      attack_seen <= 1'b0;
    end else if (hit) begin
      attack_seen <= 1'b1; // RULE15
    end else if (expire || !prev_on) begin
      attack_seen <= 1'b0; // RULE15
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      attack_event <= 1'b0;
    end else begin
      attack_event <= raise_event; // RULE13 RULE14
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= dapf_pkg::INT_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == dapf_pkg::INT_EVENT && raise_event) ||
            (i == dapf_pkg::INT_DROP && hit))
          int_stat[i] <= 1'b1;
        else if (wr_fire && s_axi_wstrb[0] && s_axi_wdata[i] &&
                 s_axi_awaddr == dapf_pkg::ADDR_INT_STAT)
          int_stat[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (int_stat & int_mask) != 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // axi read channel
  // ---------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_rdata = 32'h00000000;
    next_rresp = dapf_pkg::RESP_OKAY;
    if (s_axi_araddr[1:0] != 2'h0) begin
      next_rresp = dapf_pkg::RESP_DECERR;
    end else if (s_axi_araddr >= dapf_pkg::ADDR_CNT_BASE &&
                 s_axi_araddr <= dapf_pkg::ADDR_CNT_LAST) begin
      next_rdata = cnt[s_axi_araddr[4:2]]; // RULE12
    end else begin
      case (s_axi_araddr)
        dapf_pkg::ADDR_CTRL:     next_rdata = ctrl;
        dapf_pkg::ADDR_ALL:      next_rdata = {31'h0, &enable};
        dapf_pkg::ADDR_ENABLE:   next_rdata = {24'h0, enable};
        dapf_pkg::ADDR_TARGET:   next_rdata = target_ip;
        dapf_pkg::ADDR_INT_STAT: next_rdata = {30'h0, int_stat};
        dapf_pkg::ADDR_INT_MASK: next_rdata = {30'h0, int_mask};
        dapf_pkg::ADDR_STATUS: begin
          next_rdata[dapf_pkg::STAT_SEEN]   = attack_seen;
          next_rdata[dapf_pkg::STAT_ACTIVE] = prev_on;
          next_rdata[dapf_pkg::STAT_EN_LSB +: 8] = enable; // RULE12
        end
        default:                 next_rresp = dapf_pkg::RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= dapf_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_pkt_sig(int s);
    pkt_valid && enable[s];
  endsequence

  property p_eq_port;
    s_pkt_sig(dapf_pkg::SIG_EQ_PORT) ##0 (is_l4 &&
      pkt.src_port == pkt.dst_port) |=> drop && drop_vec[0];
  endproperty
  a_eq_port: assert property (p_eq_port) // RULE1
    else $error("equal ports not dropped");

  property p_eq_addr;
    s_pkt_sig(dapf_pkg::SIG_EQ_ADDR) ##0 (pkt.is_ip &&
      pkt.src_ip == target_ip && pkt.dst_ip == target_ip) |=> drop_vec[1];
  endproperty
  a_eq_addr: assert property (p_eq_addr) // RULE2
    else $error("equal addresses not dropped");

  property p_null;
    drop_vec[2] |-> $past(pkt.tcp_flags) == 6'h00 &&
      $past(pkt.tcp_seq) == 32'h00000000 && $past(pkt.is_tcp);
  endproperty
  a_null: assert property (p_null) // RULE3
    else $error("null scan flagged wrongly");

  property p_syn_fin;
    s_pkt_sig(dapf_pkg::SIG_SYN_FIN) ##0 (pkt.is_tcp &&
      pkt.tcp_flags[1:0] == 2'h3) |=> drop_vec[3];
  endproperty
  a_syn_fin: assert property (p_syn_fin) // RULE4
    else $error("syn fin not dropped");

  property p_low_port;
    drop_vec[4] |-> $past(pkt.src_port) < 16'h0400 &&
      $past(pkt.tcp_flags[1]);
  endproperty
  a_low_port: assert property (p_low_port) // RULE5
    else $error("low port flag without cause");

  property p_xmas;
    s_pkt_sig(dapf_pkg::SIG_XMAS) ##0 (pkt.is_tcp && seq_zero &&
      (pkt.tcp_flags & 6'h29) == 6'h29) |=> drop_vec[5];
  endproperty
  a_xmas: assert property (p_xmas) // RULE6
    else $error("xmas scan not dropped");

  property p_disabled;
    (pkt_valid && enable == 8'h00) |=> !drop ##1 !attack_event;
  endproperty
  a_disabled: assert property (p_disabled) // RULE9
    else $error("drop while all checks off");

  property p_all_off;
    (all_write && !s_axi_wdata[0]) |=> enable == 8'h00 && cnt[0] == 32'h0;
  endproperty
  a_all_off: assert property (p_all_off) // RULE10
    else $error("collective disable failed");

  sequence s_seen_expire;
    attack_seen && expire && ctrl[0];
  endsequence

  property p_event;
    attack_event |-> $past(attack_seen) && $past(expire);
  endproperty
  a_event: assert property (p_event) // RULE13
    else $error("event without attacked interval");

  property p_event_gate;
    s_seen_expire |=> attack_event ##1 !attack_event;
  endproperty
  a_event_gate: assert property (p_event_gate) // RULE14
    else $error("gated event missing or long");

  property p_seen_clear;
    (expire && !hit) |=> !attack_seen;
  endproperty
  a_seen_clear: assert property (p_seen_clear) // RULE15
    else $error("seen flag not cleared at expiry");

endmodule

// file: dapf_pkt_src.sv
// parser model: one header summary per bench request
// assumes request changes by nba after the rising edge
`timescale 1ns/10ps
module dapf_pkt_src (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // request from bench
  input  wire logic                req,
  input  wire dapf_pkg::dapf_pkt_s req_pkt,
  // toward filter
  output logic                     pkt_valid,
  output dapf_pkg::dapf_pkt_s      pkt
);
  // ------------
  // summary slot, scrambled when idle
  // ------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pkt_valid <= 1'b0;
      pkt       <= '0;
    end else begin
      pkt_valid <= req;
      pkt       <= req ? req_pkt : ~pkt;
    end
  end
endmodule

// file: tb.sv
// bench of the attack filter: packets, registers, interval event
// assumes dapf_pkt_src as parser and a 50-cycle interval
`timescale 1ns/10ps
module tb;
  // ------------
  // signals
  // ------------
  logic                clock   = 1'b0;
  logic                rst_n   = 1'b0;
  logic                req     = 1'b0;
  dapf_pkg::dapf_pkt_s rp      = '0;
  dapf_pkg::dapf_pkt_s pkt;
  logic                pkt_valid, verdict_valid, drop, attack_event, irq;
  logic [7:0]          drop_vec;
  logic [7:0]          awaddr  = 8'h00;
  logic [7:0]          araddr  = 8'h00;
  logic [31:0]         wdata   = 32'h00000000;
  logic [31:0]         rdata;
  logic                awvalid = 1'b0;
  logic                wvalid  = 1'b0;
  logic                bready  = 1'b0;
  logic                arvalid = 1'b0;
  logic                rready  = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp;
  int                  err_count   = 0;
  int                  checks_done = 0;
  int                  cyc         = 0;
  int                  ev_n        = 0;
  localparam logic [31:0] TGT = 32'h0A000001;

  always #5 clock = ~clock;

  dapf_pkt_src u_src (.clock(clock), .rst_n(rst_n), .req(req),
    .req_pkt(rp), .pkt_valid(pkt_valid), .pkt(pkt));

  dapf_filter #(.INTERVAL_CYCLES(35'h32)) u_dut (.clock(clock),
    .rst_n(rst_n), .pkt_valid(pkt_valid), .pkt(pkt),
    .verdict_valid(verdict_valid), .drop(drop), .drop_vec(drop_vec),
    .attack_event(attack_event), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  always @(negedge clock) if (attack_event === 1'b1) ev_n++;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ------------
  // shared tasks
  // ------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(negedge clock); while (!(awready && wready));
    @(posedge clock);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(negedge clock); while (!bvalid);
    chk("bresp", 32'(bresp), 32'(e));
    @(posedge clock);
    bready <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge clock); while (!arready);
    @(posedge clock);
    arvalid <= 1'b0;
    do @(negedge clock); while (!rvalid);
    chk("rdata", rdata, e);
    chk("rresp", 32'(rresp), 32'(er));
    @(posedge clock);
    rready <= 1'b0;
  endtask

  task automatic send(dapf_pkg::dapf_pkt_s p, logic [7:0] e);
    @(posedge clock);
    req <= 1'b1;
    rp  <= p;
    @(posedge clock);
    req <= 1'b0;
    repeat (2) @(negedge clock);
    chk("verdict", 32'(verdict_valid), 32'h1);
    chk("drop", 32'(drop), 32'(|e));
    chk("vec", 32'(drop_vec), 32'(e));
  endtask

  function automatic dapf_pkg::dapf_pkt_s mk(int k);
    dapf_pkg::dapf_pkt_s p;
    p = '0;
    {p.is_ip, p.is_tcp, p.src_ip, p.dst_ip} = {2'h3, 32'h1, 32'h2};
    {p.src_port, p.dst_port, p.tcp_seq} = {16'h1000, 16'h2000, 32'h1};
    {p.tcp_flags, p.total_len, p.ihl} = {6'h10, 16'h0100, 4'h5};
    case (k)
      0: p.dst_port = 16'h1000;
      1: {p.src_ip, p.dst_ip} = {TGT, TGT};
      2: {p.tcp_seq, p.tcp_flags} = '0;
      3: p.tcp_flags = 6'h03;
      4: {p.tcp_flags, p.src_port} = {6'h02, 16'h03FF};
      5: {p.tcp_seq, p.tcp_flags} = {32'h0, 6'h29};
      6: {p.is_tcp, p.is_ping, p.frag_off, p.total_len} =
           {2'h1, 13'h1FFF, 16'h0008};
      7: p.frag_off = 13'h0001;
      8: {p.tcp_flags, p.src_port} = {6'h02, 16'h0400};
      10: {p.more_frag, p.total_len} = {1'b1, 16'h0027};
      11: {p.more_frag, p.total_len} = {1'b1, 16'h0028};
      12: {p.is_tcp, p.is_udp, p.dst_port} = {2'h1, 16'h1000};
      default: {p.is_tcp, p.is_ping, p.frag_off, p.total_len} =
           {2'h1, 13'h1FFF, 16'h0007};
    endcase
    return p;
  endfunction

  // ------------
  // scenarios
  // ------------
  task automatic reset_defaults();
    rd(dapf_pkg::ADDR_ENABLE, 32'h0, dapf_pkg::RESP_OKAY);
    rd(dapf_pkg::ADDR_CTRL, 32'h0, dapf_pkg::RESP_OKAY);
    send(mk(3), 8'h00);
  endtask

  task automatic single_enable();
    wr(dapf_pkg::ADDR_ENABLE, 32'h10, dapf_pkg::RESP_OKAY);
    send(mk(3), 8'h00);
    send(mk(4), 8'h10);
  endtask

  task automatic all_signatures();
    logic [7:0] want [13] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
      8'h40, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01};
    wr(dapf_pkg::ADDR_TARGET, TGT, dapf_pkg::RESP_OKAY);
    wr(dapf_pkg::ADDR_ALL, 32'h1, dapf_pkg::RESP_OKAY);
    rd(dapf_pkg::ADDR_ALL, 32'h1, dapf_pkg::RESP_OKAY);
    rd(dapf_pkg::ADDR_ENABLE, 32'hFF, dapf_pkg::RESP_OKAY);
    for (int k = 0; k < 13; k++)
      send(mk(k), want[k]);
    for (int i = 0; i < 8; i++)
      rd(dapf_pkg::ADDR_CNT_BASE + 8'(4 * i),
         (i == 0 || i == 4 || i == 7) ? 32'h2 : 32'h1,
         dapf_pkg::RESP_OKAY);
    wr(dapf_pkg::ADDR_ALL, 32'h0, dapf_pkg::RESP_OKAY);
    rd(dapf_pkg::ADDR_ENABLE, 32'h0, dapf_pkg::RESP_OKAY);
    rd(dapf_pkg::ADDR_CNT_LAST, 32'h0, dapf_pkg::RESP_OKAY);
    send(mk(0), 8'h00);
  endtask

  task automatic bus_refusals();
    rd(8'h40, 32'h0, dapf_pkg::RESP_DECERR);
    wr(dapf_pkg::ADDR_STATUS, 32'h1, dapf_pkg::RESP_DECERR);
  endtask

  task automatic interval_event();
    wr(dapf_pkg::ADDR_ENABLE, 32'h08, dapf_pkg::RESP_OKAY);
    wr(dapf_pkg::ADDR_INT_MASK, 32'h1, dapf_pkg::RESP_OKAY);
    wr(dapf_pkg::ADDR_INT_STAT, 32'h3, dapf_pkg::RESP_OKAY);
    ev_n = 0;
    send(mk(3), 8'h08);
    repeat (60) @(negedge clock);
    chk("gated", 32'(ev_n), 32'h0);
    chk("irq off", 32'(irq), 32'h0);
    wr(dapf_pkg::ADDR_CTRL, 32'h1, dapf_pkg::RESP_OKAY);
    ev_n = 0;
    send(mk(3), 8'h08);
    rd(dapf_pkg::ADDR_STATUS, 32'h0803, dapf_pkg::RESP_OKAY);
    repeat (60) @(negedge clock);
    chk("events", 32'(ev_n), 32'h1);
    chk("irq on", 32'(irq), 32'h1);
    rd(dapf_pkg::ADDR_STATUS, 32'h0802, dapf_pkg::RESP_OKAY);
    wr(dapf_pkg::ADDR_INT_STAT, 32'h1, dapf_pkg::RESP_OKAY);
    repeat (3) @(negedge clock);
    chk("irq clr", 32'(irq), 32'h0);
    repeat (60) @(negedge clock);
    chk("quiet", 32'(ev_n), 32'h1);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    reset_defaults();
    single_enable();
    all_signatures();
    bus_refusals();
    interval_event();
    tally_and_finish();
  end
endmodule
